// ---- src/stfc_top.sv ----
// serial transmit flag control: wishbone registers, flags, tx buffer
// assumes classic wishbone master, byte addresses, one system clock
// How it works
// R01 - cumulated underflow flag drops with any underflow, set only by software
// R02 - trigger event sets when trigger active while data valid, gating on
// R03 - trigger event clears on modify code 10 or on shift load
// R04 - no transmission start while trigger event flag is zero
// R05 - reserved bits read zero in both registers
// R06 - flag modify register always reads zero
// R07 - software-set service requests return inactive by themselves
// R08 - modify field: 01 sets valid, 10 clears valid and trigger
// R09 - writing one to bit 4 sets the cumulated underflow flag
// R10 - bit 14 clears both valid flags of receive buffer 0
// R11 - bit 15 clears both valid flags of receive buffer 1
// R12 - bits 16 to 21 pulse this channel's six service request outputs
// R13 - thirty-two entry addresses all write the one transmit buffer
// R14 - entry index captured as five-bit control info per write
// R15 - read at any entry returns the transmit buffer content
// R16 - data in bits 15:0; low-byte write sets the valid flag
// R17 - underflow indication records whether each start used valid data
// R18 - buffered word sent only while valid flag is one
// R19 - gate enable zero keeps trigger event permanently set
// R20 - service request pulse lasts exactly one clock
`timescale 1ns/1ps
module stfc_top
   import stfc_pkg::*;
(
   input wire logic i_sys_clk, // 250 mhz system clock
   input wire logic i_srst, // sync reset, high
   input wire logic i_ce, // clock enable
   input wire logic i_wb_cyc, // wishbone cycle
   input wire logic i_wb_stb, // wishbone strobe
   input wire logic i_wb_we, // wishbone write
   input wire logic [STFC_AW-1:0] i_wb_adr, // byte address
   input wire logic [3:0] i_wb_sel, // byte selects
   input wire logic [31:0] i_wb_dat, // write data
   output logic [31:0] o_wb_dat, // read data
   output logic o_wb_ack, // acknowledge
   input wire logic i_trigger_pin, // transfer trigger input, async
   input wire logic i_tx_start, // shift engine requests a start
   input wire logic i_rx0_set, // receive buffer 0 got data
   input wire logic i_rx1_set, // receive buffer 1 got data
   output logic o_tx_load, // buffered word loaded to shifter
   output logic o_tx_passive, // passive level sent this start
   output logic [15:0] o_tx_data, // word to shift register
   output logic [4:0] o_tx_ctrl_info, // control info with word
   output logic [STFC_SRQ_N-1:0] o_srq // service request outputs
);
   // register state
   logic [15:0] txbuf_reg;
   logic [4:0] tci_reg;
   logic trg_en_reg;
   logic tv_reg;
   logic tvc_reg;
   logic [3:0] rxv_reg;
   logic [3:0] rxv_next;
   logic ack_reg;
   logic [31:0] rdat_reg;
   logic load_reg;
   logic passive_reg;
   logic [STFC_SRQ_N-1:0] srq_reg;
   logic [2:0] trg_sync_reg;
   logic trg_lvl_reg;
   stfc_wr_if wif();

   // address decode
   wire logic req = i_wb_cyc && i_wb_stb && !ack_reg;
   wire logic wr = req && i_wb_we;
   wire logic hit_ctrl = (i_wb_adr == STFC_OFS_CTRL);
   wire logic hit_fm = (i_wb_adr == STFC_OFS_FLAG_MODIFY);
   wire logic hit_rx = (i_wb_adr == STFC_OFS_RX_STATUS);
   wire logic hit_tb = (i_wb_adr[7] == STFC_OFS_TXBUF_BASE[7]) && (i_wb_adr[1:0] == 2'h0); // R13
   wire logic [4:0] entry_idx = i_wb_adr[6:2];
   wire logic fm_we = wr && hit_fm && (&i_wb_sel);
   wire logic tb_we = wr && hit_tb && i_wb_sel[0]; // R16
   wire logic ctrl_we = wr && hit_ctrl && i_wb_sel[1];
   wire logic [31:0] fm_d = i_wb_dat;

   // transmission start gating: valid data and trigger event required
   wire logic start_ok = wif.tx_data_valid_flag && wif.te; // R04 R18
   wire logic start_load = i_tx_start && start_ok;

   // transmit control word view; reserved bits stay zero
   wire logic [31:0] ctrl_view = {3'h0, wif.te, tvc_reg, tv_reg, 13'h0,
      trg_en_reg, 4'h0, wif.tx_data_valid_flag, 2'h0, tci_reg}; // R05
   wire logic [31:0] rx_view = {1'b0, rxv_reg[3:2], 12'h0, 1'b0, 1'b0, rxv_reg[1:0], 13'h0};
   // read mux; flag modify and unmapped read zero
   wire logic [31:0] rd_mux = hit_ctrl ? ctrl_view :
                              hit_rx ? rx_view :
                              hit_tb ? {16'h0, txbuf_reg} : // R15
                              32'h0; // R06

   assign wif.fm_we = fm_we;
   assign wif.fm_data = fm_d;
   assign wif.tb_we = tb_we;
   assign wif.trg_en = trg_en_reg;
   assign wif.trg = trg_lvl_reg;
   assign wif.load = start_load; // R03

   stfc_flags u_flags (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .w(wif)
   );

   // bus answer: ack one cycle after the request
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0;
      end else if (i_ce) begin
         ack_reg <= req;
         rdat_reg <= (req && !i_wb_we) ? rd_mux : 32'h0;
      end
   end

   // trigger pin synchroniser, change accepted once stages two and three agree
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         trg_sync_reg <= 3'h0;
         trg_lvl_reg <= 1'b0;
      end else if (i_ce) begin
         trg_sync_reg <= {trg_sync_reg[1:0], i_trigger_pin};
         if (trg_sync_reg[1] == trg_sync_reg[2]) begin
            trg_lvl_reg <= trg_sync_reg[2];
         end
      end
   end

   // transmit buffer and control info
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         txbuf_reg <= STFC_TXBUF_RST;
         tci_reg <= 5'h0;
         trg_en_reg <= 1'b0;
      end else if (i_ce) begin
         if (tb_we) begin
            txbuf_reg[7:0] <= i_wb_dat[7:0]; // R13
            if (i_wb_sel[1]) begin
               txbuf_reg[15:8] <= i_wb_dat[15:8];
            end
            tci_reg <= entry_idx; // R14
         end
         if (ctrl_we) begin
            trg_en_reg <= i_wb_dat[STFC_TCS_TRG_EN]; // R19
         end
      end
   end

   // underflow indication and cumulated flag
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         tv_reg <= STFC_TV_RST;
         tvc_reg <= STFC_TVC_RST;
      end else if (i_ce) begin
         if (i_tx_start) begin
            tv_reg <= start_ok; // R17
         end
         if (i_tx_start && !start_ok) begin
            tvc_reg <= 1'b0; // R01
         end else if (fm_we && fm_d[STFC_FM_RESTART]) begin
            tvc_reg <= 1'b1; // R09
         end
      end
   end

   // receive valid flags: new data wins over software clear
   assign rxv_next[0] = i_rx0_set ? 1'b1 : (fm_we && fm_d[STFC_FM_RX0_CLR]) ? 1'b0 : rxv_reg[0]; // R10
   assign rxv_next[1] = i_rx0_set ? 1'b1 : (fm_we && fm_d[STFC_FM_RX0_CLR]) ? 1'b0 : rxv_reg[1]; // R10
   assign rxv_next[2] = i_rx1_set ? 1'b1 : (fm_we && fm_d[STFC_FM_RX1_CLR]) ? 1'b0 : rxv_reg[2]; // R11
   assign rxv_next[3] = i_rx1_set ? 1'b1 : (fm_we && fm_d[STFC_FM_RX1_CLR]) ? 1'b0 : rxv_reg[3]; // R11
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         rxv_reg <= 4'h0;
      end else if (i_ce) begin
         rxv_reg <= rxv_next;
      end
   end

   // service request pulses and load outputs
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         srq_reg <= '0;
         load_reg <= 1'b0;
         passive_reg <= 1'b0;
         o_tx_data <= 16'h0;
         o_tx_ctrl_info <= 5'h0;
      end else if (i_ce) begin
         srq_reg <= fm_we ? fm_d[STFC_FM_SRQ_LSB +: STFC_SRQ_N] : '0; // R07 R12 R20
         load_reg <= start_load;
         passive_reg <= i_tx_start && !start_ok;
         if (start_load) begin
            o_tx_data <= txbuf_reg;
            o_tx_ctrl_info <= tci_reg;
         end
      end
   end

   assign o_wb_ack = ack_reg;
   assign o_wb_dat = rdat_reg;
   assign o_srq = srq_reg;
   assign o_tx_load = load_reg;
   assign o_tx_passive = passive_reg;
endmodule // stfc_top

// ---- src/stfc_pkg.sv ----
// package of constants for the serial transmit flag control block
// assumes a 32-bit classic wishbone slave addressed in bytes
package stfc_pkg;
   localparam int STFC_AW = 8;
   // register byte offsets
   localparam logic [7:0] STFC_OFS_CTRL = 8'h38;
   localparam logic [7:0] STFC_OFS_FLAG_MODIFY = 8'h68;
   localparam logic [7:0] STFC_OFS_TXBUF_BASE = 8'h80;
   localparam logic [7:0] STFC_OFS_RX_STATUS = 8'h70;
   // transmit control word fields
   localparam int STFC_TCS_TDV = 7;
   localparam int STFC_TCS_TRG_EN = 12;
   localparam int STFC_TCS_TV = 26;
   localparam int STFC_TCS_TVC = 27;
   localparam int STFC_TCS_TE = 28;
   localparam int STFC_TCS_TCI_LSB = 0;
   // flag modify fields
   localparam int STFC_FM_TX_VALID_MODIFY_FIELD_LSB = 0;
   localparam int STFC_FM_RESTART = 4;
   localparam int STFC_FM_RX0_CLR = 14;
   localparam int STFC_FM_RX1_CLR = 15;
   localparam int STFC_FM_SRQ_LSB = 16;
   localparam int STFC_SRQ_N = 6;
   localparam int STFC_TX_ENTRIES = 32;
   // rx status bit positions
   localparam int STFC_RX0_VA = 13;
   localparam int STFC_RX0_VB = 14;
   localparam int STFC_RX1_VA = 29;
   localparam int STFC_RX1_VB = 30;
   // tx valid modify codes
   localparam logic [1:0] STFC_TX_VALID_MODIFY_FIELD_NONE = 2'h0;
   localparam logic [1:0] STFC_TX_VALID_MODIFY_FIELD_SET = 2'h1;
   localparam logic [1:0] STFC_TX_VALID_MODIFY_FIELD_CLR = 2'h2;
   // reset values
   localparam logic [15:0] STFC_TXBUF_RST = 16'h0000;
   localparam logic STFC_TVC_RST = 1'b1;
   localparam logic STFC_TV_RST = 1'b1;
endpackage

// ---- src/stfc_wr_if.sv ----
// bundle carrying one decoded register write from the top to the flag unit
// assumes a single clock domain
`timescale 1ns/1ps
interface stfc_wr_if;
   logic fm_we; // flag modify write strobe
   logic [31:0] fm_data; // flag modify write data
   logic tb_we; // transmit buffer write covering low byte
   logic trg_en; // trigger gate enable level
   logic trg; // synchronised trigger level
   logic load; // word loaded into shift register
   logic tx_data_valid_flag; // data valid flag
   logic te; // trigger event flag
   modport top (output fm_we, fm_data, tb_we, trg_en, trg, load, input tx_data_valid_flag, te);
   modport unit (input fm_we, fm_data, tb_we, trg_en, trg, load, output tx_data_valid_flag, te);
endinterface

// ---- src/stfc_flags.sv ----
// data valid and trigger event flags of the transmit path
// assumes write strobes are one-cycle pulses on the same clock
`timescale 1ns/1ps
module stfc_flags
   import stfc_pkg::*;
(
   input wire logic i_sys_clk, // system clock
   input wire logic i_srst, // sync reset, high
   input wire logic i_ce, // clock enable
   stfc_wr_if.unit w // write bundle
);
   logic tdv_reg;
   logic tdv_next;
   logic te_reg;
   logic te_next;
   wire logic [1:0] tx_valid_modify_field = w.fm_data[STFC_FM_TX_VALID_MODIFY_FIELD_LSB +: 2];
   wire logic tx_valid_modify_field_set = w.fm_we && (tx_valid_modify_field == STFC_TX_VALID_MODIFY_FIELD_SET); // R08
   wire logic tx_valid_modify_field_clr = w.fm_we && (tx_valid_modify_field == STFC_TX_VALID_MODIFY_FIELD_CLR); // R08
   // valid flag: writes set it, modify code 10 or a load clears it
   assign tdv_next = (w.tb_we || tx_valid_modify_field_set) ? 1'b1 : // R16
                     (tx_valid_modify_field_clr || w.load) ? 1'b0 : tdv_reg;
   // trigger event: held set when gating off, else set by trigger while valid
   assign te_next = !w.trg_en ? 1'b1 : // R19
                    (w.trg && tdv_reg) ? 1'b1 : // R02
                    (tx_valid_modify_field_clr || w.load) ? 1'b0 : te_reg; // R03
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         tdv_reg <= 1'b0;
         te_reg <= 1'b0;
      end else if (i_ce) begin
         tdv_reg <= tdv_next;
         te_reg <= te_next;
      end
   end
   assign w.tx_data_valid_flag = tdv_reg;
   assign w.te = te_reg;
endmodule // stfc_flags

// ---- testbench/stfc_sva.sv ----
// checker of bus timing, flag modify reads, reserved bits and request pulses
// assumes binding to stfc_top, one clock, sync reset high, clock enable held high
`timescale 1ns/1ps
module stfc_sva
   import stfc_pkg::*;
(
   input wire logic i_sys_clk, // clock
   input wire logic i_srst, // reset
   input wire logic i_wb_cyc, // cycle
   input wire logic i_wb_stb, // strobe
   input wire logic i_wb_we, // write
   input wire logic [STFC_AW-1:0] i_wb_adr, // address
   input wire logic [31:0] i_wb_dat, // write data
   input wire logic [31:0] o_wb_dat, // read data
   input wire logic o_wb_ack, // ack
   input wire logic i_tx_start, // start
   input wire logic o_tx_load, // load
   input wire logic o_tx_passive, // passive start
   input wire logic [STFC_SRQ_N-1:0] o_srq // requests
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   // request taken, flag modify write taken, read answered
   sequence s_take;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_fm_wr;
      s_take ##0 (i_wb_we && i_wb_adr == STFC_OFS_FLAG_MODIFY);
   endsequence
   sequence s_rd_ack;
      o_wb_ack && !i_wb_we;
   endsequence
   // bus timing and read data
   a_ack_next: assert property (s_take |=> o_wb_ack) else $error("ack late");
   a_ack_once: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
   a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data idle");
   a_fm_zero: assert property ((s_rd_ack ##0 i_wb_adr == STFC_OFS_FLAG_MODIFY)
      |-> o_wb_dat == 32'h0) else $error("modify read");
   a_ctrl_rsvd: assert property ((s_rd_ack ##0 i_wb_adr == STFC_OFS_CTRL)
      |-> (o_wb_dat & 32'he2ffc200) == 32'h0) else $error("reserved bits");
   a_buf_upper: assert property ((s_rd_ack ##0 i_wb_adr[7])
      |-> o_wb_dat[31:16] == 16'h0) else $error("buffer upper half");
   // service requests follow the write and drop by themselves
   a_srq_value: assert property (s_fm_wr |=> o_srq == $past(i_wb_dat[21:16]))
      else $error("request value");
   a_srq_short: assert property (o_srq != 6'h0 |=> o_srq == 6'h0)
      else $error("request held");
   a_srq_cause: assert property (o_srq != 6'h0 |-> $past(i_wb_we)
      && $past(i_wb_adr) == STFC_OFS_FLAG_MODIFY) else $error("request cause");
   // starts only on request of the shift engine
   a_start_cause: assert property (o_tx_load || o_tx_passive |-> $past(i_tx_start))
      else $error("start cause");
endmodule // stfc_sva
bind stfc_top stfc_sva u_sva (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
   .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_tx_start(i_tx_start), .o_tx_load(o_tx_load),
   .o_tx_passive(o_tx_passive), .o_srq(o_srq));

// ---- testbench/stfc_top_test.sv ----
// self-checking bench: reads, loads and requests against noted values
// assumes stfc_top as declared, clock enable high except for one cycle in the receive test
`timescale 1ns/1ps
module stfc_top_test
   import stfc_pkg::*;
;
   localparam logic [31:0] all_m = 32'hffffffff;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic start = 1'b0;
   logic trg = 1'b0;
   logic rxs = 1'b0;
   logic ce = 1'b1;
   int psv_n = 0;
   logic [7:0] adr = 8'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdat;
   logic ack, load, passive;
   logic [15:0] txd, d0, d1;
   logic [4:0] tx_control_info, k0, k1;
   logic [5:0] srq;
   logic [63:0] note;
   logic [63:0] rd_q[$];
   logic [20:0] ld_q[$];
   logic [5:0] srq_q[$];
   int n_mismatch = 0;
   int check_count = 0;
   int seed = 14570;
   int i;
   always #2 clk = ~clk;
   stfc_top u_dut (.i_sys_clk(clk), .i_srst(srst), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_trigger_pin(trg), .i_tx_start(start), .i_rx0_set(rxs),
      .i_rx1_set(rxs), .o_tx_load(load), .o_tx_passive(passive), .o_tx_data(txd),
      .o_tx_ctrl_info(tx_control_info), .o_srq(srq));
   task automatic summarize();
      $display("counts: %0d checks, %0d mismatches", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      n = 0;
      do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
      if (ack !== 1'b1) begin
         n_mismatch++;
         summarize();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      rd_q.push_back({m, e & m});
      wb(1'b0, a, 4'hf, 32'h0);
   endtask
   task automatic fm(input logic [31:0] d);
      if (d[21:16] != 6'h0) srq_q.push_back(d[21:16]);
      wb(1'b1, STFC_OFS_FLAG_MODIFY, 4'hf, d);
   endtask
   task automatic go();
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // monitor: each result takes the oldest note of its kind
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0) begin
         note = (rd_q.size() > 0) ? rd_q.pop_front() : {32'h0, 32'h1};
         cmp("read", note[31:0], rdat & note[63:32]);
      end
      if (load === 1'b1) cmp("load", (ld_q.size() > 0) ? ld_q.pop_front() : ~{tx_control_info, txd}, {tx_control_info, txd});
      if (srq !== 6'h0) cmp("request", (srq_q.size() > 0) ? srq_q.pop_front() : ~srq, srq);
      // passive starts are only expected where the bench announced one
      if (passive === 1'b1) begin
         cmp("passive", {31'h0, psv_n > 0}, 32'h1);
         if (psv_n > 0) psv_n--;
      end
   end
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rd(STFC_OFS_CTRL, 32'h1c000000, all_m);
      rd(STFC_OFS_FLAG_MODIFY, 32'h0, all_m);
      rd(STFC_OFS_RX_STATUS, 32'h0, all_m);
      rd(8'h00, 32'h0, all_m);
      $display("test reset done");
      d0 = $random(seed);
      k0 = $random(seed);
      wb(1'b1, STFC_OFS_TXBUF_BASE + {1'b0, k0, 2'b00}, 4'h3, {16'hffff, d0});
      rd(STFC_OFS_TXBUF_BASE + {1'b0, ~k0, 2'b00}, {16'h0, d0}, all_m);
      rd(STFC_OFS_CTRL, 32'h1c000080 | k0, all_m);
      ld_q.push_back({k0, d0});
      go();
      rd(STFC_OFS_CTRL, 32'h1c000000, 32'h1c000000);
      $display("test buffer done");
      fm(32'h2);
      rd(STFC_OFS_CTRL, 32'h0, 32'h80);
      psv_n++;
      go();
      rd(STFC_OFS_CTRL, 32'h0, 32'h0c000080);
      fm(32'h10);
      rd(STFC_OFS_CTRL, 32'h08000000, 32'h0c000000);
      fm(32'h1);
      rd(STFC_OFS_CTRL, 32'h10000080, 32'h10000080);
      $display("test underflow done");
      wb(1'b1, STFC_OFS_CTRL, 4'h2, 32'h1000);
      fm(32'h2);
      d1 = $random(seed);
      k1 = $random(seed);
      wb(1'b1, STFC_OFS_TXBUF_BASE + {1'b0, k1, 2'b00}, 4'h3, {16'h0, d1});
      rd(STFC_OFS_CTRL, 32'h1080 | k1, 32'h1000109f);
      psv_n++;
      go();
      trg <= 1'b1;
      repeat (8) @(posedge clk);
      trg <= 1'b0;
      // let the synchronised trigger fall, else it sets the event again at load
      repeat (8) @(posedge clk);
      rd(STFC_OFS_CTRL, 32'h10000000, 32'h10000000);
      ld_q.push_back({k1, d1});
      go();
      rd(STFC_OFS_CTRL, 32'h04000000, 32'h14000000);
      $display("test trigger done");
      // clock enable low freezes the receive flags
      ce <= 1'b0;
      rxs <= 1'b1;
      @(posedge clk);
      rxs <= 1'b0;
      ce <= 1'b1;
      rd(STFC_OFS_RX_STATUS, 32'h0, all_m);
      rxs <= 1'b1;
      @(posedge clk);
      rxs <= 1'b0;
      rd(STFC_OFS_RX_STATUS, 32'h60006000, all_m);
      fm(32'h4000);
      rd(STFC_OFS_RX_STATUS, 32'h60000000, all_m);
      fm(32'h8000);
      rd(STFC_OFS_RX_STATUS, 32'h0, all_m);
      $display("test receive done");
      for (i = 0; i < 6; i++) fm(32'h10000 << i);
      d0 = $random(seed);
      fm({10'h0, d0[5:0], 16'h0});
      repeat (4) @(posedge clk);
      $display("test requests done");
      if (rd_q.size() + ld_q.size() + srq_q.size() + psv_n != 0) n_mismatch++;
      summarize();
   end
endmodule // stfc_top_test
